// ===== logic/strap_mux_pkg.sv
package strap_mux_pkg;

   // strap level code from the analog sense front end
   typedef enum logic [2:0] {
      lvl_weak_down   = 3'h0,
      lvl_weak_up     = 3'h1,
      lvl_medium_down = 3'h2,
      lvl_medium_up   = 3'h3,
      lvl_strong_down = 3'h4,
      lvl_strong_up   = 3'h5
   } strap_level_t;

   // pin function codes
   typedef enum logic [5:0] {
      fn_none           = 6'h00,
      fn_p1_conn_pwr_a  = 6'h01,
      fn_p1_conn_pwr_b  = 6'h02,
      fn_p1_discharge   = 6'h03,
      fn_gpio0          = 6'h04,
      fn_gpio1          = 6'h05,
      fn_gpio2          = 6'h06,
      fn_gpio3          = 6'h07,
      fn_p1_pwr         = 6'h08,
      fn_p2_pwr         = 6'h09,
      fn_p3_pwr         = 6'h0a,
      fn_p4_pwr         = 6'h0b,
      fn_p5_pwr         = 6'h0c,
      fn_p6_pwr         = 6'h0d,
      fn_p2_ss_pwr      = 6'h0e,
      fn_p3_ss_pwr      = 6'h0f,
      fn_p4_ss_pwr      = 6'h10,
      fn_alert_in       = 6'h11,
      fn_mic_detect     = 6'h12,
      fn_audio_din      = 6'h13,
      fn_audio_dout     = 6'h14,
      fn_audio_mclk     = 6'h15,
      fn_audio_bclk     = 6'h16,
      fn_audio_ws       = 6'h17,
      fn_flash_cs_n     = 6'h18,
      fn_flash_clk      = 6'h19,
      fn_flash_d0       = 6'h1a,
      fn_flash_d1       = 6'h1b,
      fn_flash_d2       = 6'h1c,
      fn_flash_d3       = 6'h1d,
      fn_tgt_tw_clk     = 6'h1e,
      fn_tgt_tw_data    = 6'h1f,
      fn_bridge_tw_clk  = 6'h20,
      fn_bridge_tw_data = 6'h21
   } pin_fn_t;

   // capture sequencer, gray along reset -> settle -> capture -> held
   typedef enum logic [1:0] {
      st_reset   = 2'b00,
      st_settle  = 2'b01,
      st_capture = 2'b11,
      st_held    = 2'b10
   } cap_state_t;

   localparam int          NUM_PORTS     = 6;
   localparam int          PF_FIRST      = 3;
   localparam int          PF_LAST       = 31;
   localparam int          NUM_PF        = PF_LAST - PF_FIRST + 1;
   localparam int          FN_W          = 6;
   localparam logic [5:0]  DIS_RESET     = 6'h00;
   localparam logic [2:0]  COUNT_RESET   = 3'h0;
   localparam logic        MAP_RESET     = 1'b0;
   // straps pass three flops; settle covers the synchroniser depth
   localparam logic [1:0]  SETTLE_CYCLES = 2'h3;

endpackage

// ===== logic/strap_level_decode.sv
`timescale 1ns/1ps
// maps a strap level code to a count of ports 0,1,2,3,4,6
module strap_level_decode
   import strap_mux_pkg::*;
(
   // level in
   input  wire strap_level_t level,
   // decoded count
   output logic [2:0]        port_count,
   output logic [5:0]        port_mask
);

   // same level order serves both count straps
   always_comb begin
      case (level)
         lvl_weak_down:   port_count = 3'h0;
         lvl_weak_up:     port_count = 3'h1;
         lvl_medium_down: port_count = 3'h2;
         lvl_medium_up:   port_count = 3'h3;
         lvl_strong_down: port_count = 3'h4;
         lvl_strong_up:   port_count = 3'h6;
         default:         port_count = 3'h0; // unknown code: safest setting
      endcase
      port_mask = 6'(({6'h00, 6'h3f} << port_count) >> 6);
   end

endmodule

// ===== logic/strap_pin_mux.sv
`timescale 1ns/1ps
// How it works
// - every strap is sampled once when reset is released and held until the next reset.
// - a port is disabled only when both its plus-line and minus-line straps read 1.
// - a port disabled by straps also has its superspeed path disabled.
// - the fixed-port strap level picks none, 1, 1-2, 1-3, 1-4 or 1-6 non-removable ports.
// - the charging strap level picks the same port counts for charging enable.
// - pins 3 to 31 take defaults from one of two maps chosen by the map select straps.
// - both selects low give map 1, select 1 high with select 2 low gives map 2, others are reserved.
// - pins shared by both maps carry port 1 power, io, port power, alert, flash and bridge bus.
// - map 1 puts io on 7, superspeed power on 10-11, nothing on 19, target bus on 26-27, port 6 on 28.
// - map 2 puts mic detect on 7, audio on 10, 11, 19, 26, 28 and port 6 power on 27.
// - pin 29 has no default function in either map.
// - override inputs replace any pin's default function.
module strap_pin_mux
   import strap_mux_pkg::*;
(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // strap inputs, asynchronous pins
   input  wire logic [5:0]   port_plus_line_disable_strap,
   input  wire logic [5:0]   port_minus_line_disable_strap,
   input  wire logic [2:0]   fixed_port_count_strap,
   input  wire logic [2:0]   charging_port_count_strap,
   input  wire logic [1:0]   map_select_strap,
   // pin mux override, from configuration logic on clk_sys
   input  wire logic [28:0]  pf_override_en,
   input  wire logic [173:0] pf_override_fn,
   // captured configuration
   output logic              strap_valid,
   output logic [5:0]        port_disable,
   output logic [5:0]        port_ss_disable,
   output logic [2:0]        fixed_port_count,
   output logic [5:0]        fixed_port_mask,
   output logic [2:0]        charging_port_count,
   output logic [5:0]        charging_port_mask,
   output logic              map_two,
   output logic              map_reserved,
   // per pin function, pin 3 in the low field
   output logic [173:0]      programmable_function_pin
);

   localparam int SYNC_W = 20;
   // three-flop synchroniser; first stage read only by the second
   logic [SYNC_W-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d, strap_raw;
   assign strap_raw = {map_select_strap, charging_port_count_strap, fixed_port_count_strap,
                       port_minus_line_disable_strap, port_plus_line_disable_strap};
   always_comb begin
      s1_d = strap_raw;
      s2_d = s1_q;
      s3_d = s2_q;
   end

   always_ff @(posedge clk_sys) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
   end
   // agreed strap view: stages two and three match
   logic strap_stable;
   assign strap_stable = (s2_q == s3_q);
   // capture sequencer
   cap_state_t state_q, state_d;
   logic [1:0] settle_q, settle_d;
   always_comb begin
      state_d  = state_q;
      settle_d = settle_q;
      case (state_q)
         st_reset: begin
            state_d  = st_settle;
            settle_d = SETTLE_CYCLES;
         end
         st_settle: begin
            // wait out the synchroniser so captured values reflect post-release pins
            if (settle_q != 2'h0) begin
               settle_d = settle_q - 2'h1;
            end else begin
               state_d = st_capture;
            end
         end
         st_capture: begin
            if (strap_stable) begin
               state_d = st_held;
            end
         end
         st_held: state_d = st_held; // held until the next reset
         default: state_d = st_reset;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q  <= st_reset;
         settle_q <= 2'h0;
      end else begin
         state_q  <= state_d;
         settle_q <= settle_d;
      end
   end
   // captured straps; a strap that is still moving is a board fault, not filtered further
   logic [SYNC_W-1:0] cap_q, cap_d;
   logic              valid_q, valid_d;

   always_comb begin
      cap_d   = cap_q;
      valid_d = valid_q;
      if (state_q == st_capture && strap_stable) begin
         cap_d   = s3_q;
         valid_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cap_q   <= '0;
         valid_q <= 1'b0;
      end else begin
         cap_q   <= cap_d;
         valid_q <= valid_d;
      end
   end
   // field views of the captured word
   logic [5:0]   cap_plus, cap_minus;
   strap_level_t cap_fixed, cap_chg;
   logic [1:0]   cap_sel;
   assign cap_plus  = cap_q[5:0];
   assign cap_minus = cap_q[11:6];
   assign cap_fixed = strap_level_t'(cap_q[14:12]);
   assign cap_chg   = strap_level_t'(cap_q[17:15]);
   assign cap_sel   = cap_q[19:18];
   // level decoders
   logic [2:0] fixed_cnt, chg_cnt;
   logic [5:0] fixed_msk, chg_msk;
   strap_level_decode u_fixed_dec (
      .level      (cap_fixed),
      .port_count (fixed_cnt),
      .port_mask  (fixed_msk)
   );
   strap_level_decode u_chg_dec (
      .level      (cap_chg),
      .port_count (chg_cnt),
      .port_mask  (chg_msk)
   );
   // default function table
   function automatic pin_fn_t default_fn(input int pin, input logic alt);
      pin_fn_t f;
      f = fn_none;
      case (pin)
         3:  f = fn_p1_conn_pwr_b;
         4:  f = fn_p1_conn_pwr_a;
         5:  f = fn_p1_discharge;
         6:  f = fn_gpio0;
         7:  f = alt ? fn_mic_detect : fn_gpio1;
         8:  f = fn_gpio2;
         9:  f = fn_gpio3;
         10: f = alt ? fn_audio_din : fn_p2_ss_pwr;
         11: f = alt ? fn_audio_mclk : fn_p3_ss_pwr;
         12: f = fn_p4_ss_pwr;
         13: f = fn_p4_pwr;
         14: f = fn_p3_pwr;
         15: f = fn_p2_pwr;
         16: f = fn_p5_pwr;
         17: f = fn_p1_pwr;
         18: f = fn_alert_in;
         19: f = alt ? fn_audio_dout : fn_none;
         20: f = fn_flash_cs_n;
         21: f = fn_flash_clk;
         22: f = fn_flash_d0;
         23: f = fn_flash_d1;
         24: f = fn_flash_d2;
         25: f = fn_flash_d3;
         26: f = alt ? fn_audio_bclk : fn_tgt_tw_clk;
         27: f = alt ? fn_p6_pwr : fn_tgt_tw_data;
         28: f = alt ? fn_audio_ws : fn_p6_pwr;
         29: f = fn_none;
         30: f = fn_bridge_tw_clk;
         31: f = fn_bridge_tw_data;
         default: f = fn_none;
      endcase
      return f;
   endfunction
   // decoded outputs, registered
   logic [5:0]   dis_q, dis_d, ssdis_q, ssdis_d, fmask_q, fmask_d, cmask_q, cmask_d;
   logic [2:0]   fcnt_q, fcnt_d, ccnt_q, ccnt_d;
   logic         map2_q, map2_d, resv_q, resv_d;
   logic [173:0] pf_q, pf_d;
   always_comb begin
      dis_d   = cap_plus & cap_minus;
      ssdis_d = dis_d;
      fmask_d = fixed_msk;
      cmask_d = chg_msk;
      fcnt_d  = fixed_cnt;
      ccnt_d  = chg_cnt;
      // reserved codes fall back to map 1
      map2_d  = (cap_sel == 2'b01);
      resv_d  = cap_sel[1];
      for (int i = 0; i < NUM_PF; i++) begin
         pf_d[i*FN_W +: FN_W] = pf_override_en[i] ? pf_override_fn[i*FN_W +: FN_W]
                                                  : default_fn(i + PF_FIRST, map2_d);
      end
      if (!valid_q) begin
         dis_d   = DIS_RESET;
         ssdis_d = DIS_RESET;
         fmask_d = DIS_RESET;
         cmask_d = DIS_RESET;
         fcnt_d  = COUNT_RESET;
         ccnt_d  = COUNT_RESET;
         map2_d  = MAP_RESET;
         resv_d  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dis_q   <= DIS_RESET;
         ssdis_q <= DIS_RESET;
         fmask_q <= DIS_RESET;
         cmask_q <= DIS_RESET;
         fcnt_q  <= COUNT_RESET;
         ccnt_q  <= COUNT_RESET;
         map2_q  <= MAP_RESET;
         resv_q  <= 1'b0;
         pf_q    <= '0;
      end else begin
         dis_q   <= dis_d;
         ssdis_q <= ssdis_d;
         fmask_q <= fmask_d;
         cmask_q <= cmask_d;
         fcnt_q  <= fcnt_d;
         ccnt_q  <= ccnt_d;
         map2_q  <= map2_d;
         resv_q  <= resv_d;
         pf_q    <= pf_d;
      end
   end
   assign strap_valid               = valid_q;
   assign port_disable              = dis_q;
   assign port_ss_disable           = ssdis_q;
   assign fixed_port_count          = fcnt_q;
   assign fixed_port_mask           = fmask_q;
   assign charging_port_count       = ccnt_q;
   assign charging_port_mask        = cmask_q;
   assign map_two                   = map2_q;
   assign map_reserved              = resv_q;
   assign programmable_function_pin = pf_q;
   // checks
   property p_cap_hold;
      @(posedge clk_sys) disable iff (rst) valid_q |=> $stable(cap_q);
   endproperty
   a_cap_hold: assert property (p_cap_hold) else $error("captured straps changed");
   // release of reset starts the settle and capture steps
   sequence s_release;
      $fell(rst);
   endsequence
   property p_valid_time;
      @(posedge clk_sys) s_release |-> ##[4:300] valid_q;
   endproperty
   a_valid_time: assert property (p_valid_time) else $error("capture late");
   property p_disable;
      @(posedge clk_sys) disable iff (rst) valid_q |=> (dis_q == $past(cap_plus & cap_minus));
   endproperty
   a_disable: assert property (p_disable) else $error("port disable wrong");
   // judged against the captured straps, not against the legacy disable register
   property p_ss;
      @(posedge clk_sys) disable iff (rst) valid_q |=> (ssdis_q == $past(cap_plus & cap_minus));
   endproperty
   a_ss: assert property (p_ss) else $error("superspeed disable mismatch");
   property p_fixed;
      @(posedge clk_sys) disable iff (rst) valid_q && cap_fixed == lvl_strong_up |=> fcnt_q == 3'h6;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed count wrong");
   property p_chg;
      @(posedge clk_sys) disable iff (rst) valid_q && cap_chg == lvl_weak_down |=> cmask_q == 6'h00;
   endproperty
   a_chg: assert property (p_chg) else $error("charging mask wrong");
   property p_pin29;
      @(posedge clk_sys) disable iff (rst) !pf_override_en[26] |=> pf_q[161:156] == fn_none;
   endproperty
   a_pin29: assert property (p_pin29) else $error("pin 29 has a function");
   property p_pin7;
      @(posedge clk_sys) disable iff (rst)
         valid_q && !pf_override_en[4] |=> pf_q[29:24] == (map2_q ? fn_mic_detect : fn_gpio1);
   endproperty
   a_pin7: assert property (p_pin7) else $error("pin 7 map wrong");
   property p_override;
      @(posedge clk_sys) disable iff (rst) pf_override_en[0] |=> pf_q[5:0] == $past(pf_override_fn[5:0]);
   endproperty
   a_override: assert property (p_override) else $error("override ignored");

endmodule

// ===== test/strap_board.sv
`timescale 1ns/1ps
// board strap resistors as seen by the chip after analog sensing
module strap_board
   import strap_mux_pkg::*;
(
   // clock and reset seen by the board
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // wanted setting, late change for fault scenarios
   input  wire logic [5:0] want_plus,
   input  wire logic [5:0] want_minus,
   input  wire logic [2:0] want_fixed,
   input  wire logic [2:0] want_charge,
   input  wire logic       want_map,
   input  wire logic       want_sel2,
   input  wire logic       late_change,
   // strap pins
   output logic [5:0]      plus_strap,
   output logic [5:0]      minus_strap,
   output logic [2:0]      fixed_strap,
   output logic [2:0]      charge_strap,
   output logic [1:0]      map_strap
);
   // levels follow the wanted setting only while the chip sits in reset or late_change is high
   always_ff @(negedge clk_sys) begin
      if (rst || late_change) begin
         plus_strap   <= want_plus;
         minus_strap  <= want_minus;
         fixed_strap  <= want_fixed;
         charge_strap <= want_charge;
         // select 2 pulled down unless a fault scenario asks for it
         map_strap    <= {want_sel2, want_map};
      end
   end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
   import strap_mux_pkg::*;
   logic          clk_sys = 1'b0;
   logic          rst = 1'b1;
   logic [5:0]    w_plus = 6'h00, w_minus = 6'h00, s_plus, s_minus, pdis, ssdis, fmask, cmask;
   logic [2:0]    w_fixed = 3'h0, w_chg = 3'h0, s_fixed, s_chg, fcnt, ccnt;
   logic [1:0]    s_map;
   logic          w_map = 1'b0, w_sel2 = 1'b0, late = 1'b0, valid, map_two, map_res;
   logic [28:0]   ov_en = 29'h0;
   logic [173:0]  ov_fn = 174'h0, pins;
   logic [2:0]    cnt_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
   pin_fn_t       map_tab [2][29];
   int            fail_count = 0, n_compared = 0, cycles = 0;

   always #12.5 clk_sys = ~clk_sys;

   strap_board board (.clk_sys(clk_sys), .rst(rst), .want_plus(w_plus), .want_minus(w_minus),
      .want_fixed(w_fixed), .want_charge(w_chg), .want_map(w_map), .want_sel2(w_sel2), .late_change(late),
      .plus_strap(s_plus), .minus_strap(s_minus), .fixed_strap(s_fixed), .charge_strap(s_chg),
      .map_strap(s_map));

   strap_pin_mux uut (.clk_sys(clk_sys), .rst(rst), .port_plus_line_disable_strap(s_plus),
      .port_minus_line_disable_strap(s_minus), .fixed_port_count_strap(s_fixed),
      .charging_port_count_strap(s_chg), .map_select_strap(s_map), .pf_override_en(ov_en),
      .pf_override_fn(ov_fn), .strap_valid(valid), .port_disable(pdis), .port_ss_disable(ssdis),
      .fixed_port_count(fcnt), .fixed_port_mask(fmask), .charging_port_count(ccnt),
      .charging_port_mask(cmask), .map_two(map_two), .map_reserved(map_res),
      .programmable_function_pin(pins));

   // hang guard, far above six captures and a few short scenarios
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic check(input logic [173:0] seen, input logic [173:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [5:0] mask_of(input logic [2:0] n);
      mask_of = 6'((7'h01 << n) - 7'h01);
   endfunction

   function automatic logic [173:0] pins_of(input int m);
      pins_of = '0;
      for (int i = 0; i < 29; i++)
         pins_of[i*6 +: 6] = map_tab[m][i];
   endfunction

   // reset for 20 cycles, then wait for capture and one edge for decode
   task automatic restart();
      int i;
      rst = 1'b1;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      for (i = 0; i < 14 && valid !== 1'b1; i++)
         @(negedge clk_sys);
      check(valid, 1'b1);
      @(negedge clk_sys);
   endtask

   // decoded outputs while held in reset are all clear
   task automatic t_in_reset();
      repeat (19) @(negedge clk_sys);
      check({valid, pdis, ssdis, fcnt, fmask, ccnt, cmask, map_two, map_res}, '0);
      check(pins, '0);
   endtask

   // every level code on both count straps, both maps, mixed disable pairs
   task automatic t_capture(input int k);
      w_plus  = 6'h2d ^ 6'(k * 9);
      w_minus = 6'h36 ^ 6'(k * 5);
      w_fixed = 3'(k);
      w_chg   = 3'(5 - k);
      w_map   = k[0];
      restart();
      check(pdis, w_plus & w_minus);
      check(ssdis, w_plus & w_minus);
      check(fcnt, cnt_tab[k]);
      check(fmask, mask_of(cnt_tab[k]));
      check(ccnt, cnt_tab[5-k]);
      check(cmask, mask_of(cnt_tab[5-k]));
      check({map_two, map_res}, {w_map, 1'b0});
      check(pins, pins_of(k % 2));
   endtask

   // strap pins moving after capture must not reach the outputs
   task automatic t_late_change();
      logic [173:0] pins_held;
      logic [32:0]  cfg_held;
      pins_held = pins;
      cfg_held  = {valid, pdis, ssdis, fcnt, fmask, ccnt, cmask, map_two, map_res};
      w_plus  = ~w_plus;
      w_minus = ~w_minus;
      w_fixed = 3'h5 - w_fixed;
      w_chg   = 3'h5 - w_chg;
      w_map   = ~w_map;
      late    = 1'b1;
      repeat (8) @(negedge clk_sys);
      late = 1'b0;
      check({valid, pdis, ssdis, fcnt, fmask, ccnt, cmask, map_two, map_res}, cfg_held);
      check(pins, pins_held);
   endtask

   // reserved map select and unused level codes: map 1, flag raised, zero ports
   task automatic t_reserved();
      w_sel2  = 1'b1;
      w_map   = 1'b0;
      w_fixed = 3'h7;
      w_chg   = 3'h6;
      restart();
      check({map_two, map_res}, 2'b01);
      check(pins, pins_of(0));
      check({fcnt, fmask}, 9'h000);
      check({ccnt, cmask}, 9'h000);
   endtask

   // overrides on the first pin and the unused pin, then released
   task automatic t_override();
      logic [173:0] exp;
      exp = pins_of(int'(map_two));
      ov_en = 29'h0400_0001;
      ov_fn[5:0] = fn_audio_ws;
      ov_fn[161:156] = fn_gpio3;
      @(negedge clk_sys);
      exp[5:0] = fn_audio_ws;
      exp[161:156] = fn_gpio3;
      check(pins, exp);
      ov_en = 29'h0;
      @(negedge clk_sys);
      check(pins, pins_of(int'(map_two)));
   endtask

   initial begin
      map_tab[0] = '{fn_p1_conn_pwr_b, fn_p1_conn_pwr_a, fn_p1_discharge, fn_gpio0, fn_gpio1, fn_gpio2,
         fn_gpio3, fn_p2_ss_pwr, fn_p3_ss_pwr, fn_p4_ss_pwr, fn_p4_pwr, fn_p3_pwr, fn_p2_pwr, fn_p5_pwr,
         fn_p1_pwr, fn_alert_in, fn_none, fn_flash_cs_n, fn_flash_clk, fn_flash_d0, fn_flash_d1,
         fn_flash_d2, fn_flash_d3, fn_tgt_tw_clk, fn_tgt_tw_data, fn_p6_pwr, fn_none, fn_bridge_tw_clk,
         fn_bridge_tw_data};
      // map 2 differs on pins 7, 10, 11, 19, 26, 27, 28 only
      map_tab[1] = map_tab[0];
      map_tab[1][4]  = fn_mic_detect;
      map_tab[1][7]  = fn_audio_din;
      map_tab[1][8]  = fn_audio_mclk;
      map_tab[1][16] = fn_audio_dout;
      map_tab[1][23] = fn_audio_bclk;
      map_tab[1][24] = fn_p6_pwr;
      map_tab[1][25] = fn_audio_ws;
      t_in_reset();
      for (int k = 0; k < 6; k++)
         t_capture(k);
      t_late_change();
      t_override();
      t_reserved();
      conclude();
   end
endmodule
